/* File: logic/rsc_top.sv */
// Reset-state, trap routing and scan-loaded configuration for one core
// Notes on behaviour
// - Hard power-on loads defined reset values into affected registers
// - Soft reset keeps affected register contents
// - First watchdog timeout in execute, later recovery
// - Trap at top level causes recovery watchdog
// - Status register scanned in before execution starts
// - Software cannot write operating status register
// - Test port may rewrite status after power-on
// - Power-on copies width choice into config
// - Narrow mode keeps low 41 address bits
// - Wide mode keeps low 43 address bits
// - Halt option keeps core halted in error
// - Each error falls into one of four classes
// - Otherwise error state exits by watchdog reset
`timescale 1ns/1ps
module rsc_top import rsc_pkg::*; (
    // Clock and hard power-on reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // System soft reset
    input wire logic SYS_SOFT_RESET_N_I,
    // Scan and test-port configuration path
    input wire logic SCAN_EN_I,
    input wire logic SCAN_IN_I,
    input wire logic SCAN_DONE_I,
    input wire logic JTAG_UPDATE_I,
    // Trap and error events
    input wire logic WDOG_TIMEOUT_I,
    input wire logic TRAP_I,
    input wire logic TRAP_RET_I,
    input wire logic RECOVERY_EXIT_I,
    input wire logic ERR_VALID_I,
    input wire logic [1:0] ERR_CLASS_I,
    // Physical address path
    input wire logic [PA_W-1:0] PA_I,
    output logic [PA_W-1:0] PA_O,
    // Register access
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [63:0] REG_WDATA_I,
    output logic [63:0] REG_RDATA_O,
    // Status
    output logic CORE_RUN_O,
    output logic RECOVERY_STATE_O,
    output logic [LVL_W-1:0] TRAP_LEVEL_O,
    output logic WD_RESET_O,
    output logic SOFT_RESET_O,
    output logic HALTED_O,
    output logic FATAL_O,
    output logic [3:0] ERR_CLASS_O
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Clip an issued address to the active width
    function automatic logic [PA_W-1:0] mask_pa(input logic [PA_W-1:0] pa,
                                                 input logic narrow);
        logic [PA_W-1:0] m;
        m = pa;
        if (narrow) begin
            m[PA_W-1:PA_NARROW_W] = '0;
        end
        return m;
    endfunction : mask_pa

    // ----------------------------------------
    // State
    // ----------------------------------------
    rsc_state_t state, next_state;          // Sequencer
    logic [OSR_W-1:0] osr, next_osr;        // operating_status_scan_register
    logic [OSR_W-1:0] shadow, next_shadow;  // Test-port staging chain
    logic narrow, next_narrow;              // bus_config_register pa_width_select
    logic [CAP_W-1:0] cap_field, next_cap_field; // master_capability_field copy
    logic [63:0] trap_match, next_trap_match;
    logic [63:0] err_mark, next_err_mark;
    logic [63:0] scratch;                   // No reset on purpose
    logic [LVL_W-1:0] trap_lvl, next_trap_lvl; // trap_level_count
    logic recov, next_recov;                // recovery_state
    logic wdog_seen, next_wdog_seen;        // First timeout already taken
    logic soft_s1, soft_s2, soft_s3;        // Soft reset synchroniser
    logic soft_fall;                        // Start of a soft reset
    logic core_run, next_core_run;
    logic wd_reset, next_wd_reset;          // watchdog_reset_event pulse
    logic halted, next_halted;
    logic fatal, next_fatal;
    logic [3:0] err_cls, next_err_cls;
    logic [63:0] rdata, next_rdata;

    // Edge detect looks only at settled stages
    assign soft_fall = soft_s3 & ~soft_s2;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_osr = osr;
        next_shadow = shadow;
        next_narrow = narrow;
        next_cap_field = cap_field;
        next_trap_match = trap_match;
        next_err_mark = err_mark;
        next_trap_lvl = trap_lvl;
        next_recov = recov;
        next_wdog_seen = wdog_seen;
        next_core_run = core_run;
        next_wd_reset = 1'b0;
        next_halted = halted;
        next_fatal = fatal;
        next_err_cls = 4'h0;
        next_rdata = rdata;
        // Configuration path
        if (state == RSC_SCAN) begin
            if (SCAN_EN_I) begin
                next_osr = {osr[OSR_W-2:0], SCAN_IN_I};
            end
        end else begin
            if (SCAN_EN_I) begin
                next_shadow = {shadow[OSR_W-2:0], SCAN_IN_I};
            end
            if (JTAG_UPDATE_I) begin
                next_osr = shadow;
            end
        end
        // Sequencer
        case (state)
            RSC_SCAN: begin
                // Core is held until the scan load is declared complete
                if (SCAN_DONE_I && !SCAN_EN_I) begin
                    next_narrow = osr[OSR_NARROW_BIT];
                    next_cap_field = osr[OSR_CAP_LSB +: CAP_W];
                    next_core_run = 1'b1;
                    next_state = RSC_RUN;
                end
            end
            RSC_RUN: begin
                // Exit goes first so a recovery entry in the same cycle wins
                if (RECOVERY_EXIT_I) begin
                    next_recov = 1'b0;
                end
                if (WDOG_TIMEOUT_I) begin
                    next_wdog_seen = 1'b1;
                    next_wd_reset = wdog_seen;
                    if (wdog_seen) begin
                        next_recov = 1'b1;
                    end
                    if (trap_lvl != TOP_TRAP_LEVEL) begin
                        next_trap_lvl = trap_lvl + 3'h1;
                    end
                end else if (TRAP_I) begin
                    if (trap_lvl == TOP_TRAP_LEVEL) begin
                        next_recov = 1'b1;
                        next_wd_reset = 1'b1;
                    end else begin
                        next_trap_lvl = trap_lvl + 3'h1;
                    end
                end else if (TRAP_RET_I && trap_lvl != '0) begin
                    next_trap_lvl = trap_lvl - 3'h1;
                end
                if (ERR_VALID_I) begin
                    next_err_cls[ERR_CLASS_I] = 1'b1;
                    if (ERR_CLASS_I == ERR_FATAL) begin
                        next_fatal = 1'b1;
                        next_core_run = 1'b0;
                        next_state = RSC_HALT;
                    end else if (ERR_CLASS_I == ERR_STATE) begin
                        next_core_run = 1'b0;
                        next_state = RSC_ERROR;
                    end
                end
            end
            RSC_ERROR: begin
                if (osr[OSR_HALT_BIT]) begin
                    next_halted = 1'b1;
                    next_state = RSC_HALT;
                end else begin
                    // Leave through a watchdog reset into the handler
                    next_wd_reset = 1'b1;
                    next_recov = 1'b1;
                    next_core_run = 1'b1;
                    next_state = RSC_RUN;
                end
            end
            RSC_HALT: begin
                // Only a reset gets the core out of here
            end
            default: begin
                next_state = RSC_SCAN;
            end
        endcase
        // Soft reset restarts the core but keeps register contents
        if (soft_fall && state != RSC_SCAN) begin
            next_state = RSC_RUN;
            next_core_run = 1'b1;
            next_recov = 1'b1;
            next_trap_lvl = '0;
            next_wdog_seen = 1'b0;
            next_halted = 1'b0;
            next_fatal = 1'b0;
        end
        // Register writes; configuration offsets are not writable
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                OFF_TRAP_MATCH: next_trap_match = REG_WDATA_I;
                OFF_ERR_MARK: next_err_mark = REG_WDATA_I;
                default: begin
                    // Identity, config and status copy ignore writes
                    next_osr = next_osr;
                end
            endcase
        end
        // Register reads
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                OFF_PORT_ID: next_rdata = PORT_ID_VALUE;
                OFF_BUS_CFG: begin
                    next_rdata = '0;
                    next_rdata[CFG_WIDTH_BIT] = narrow;
                    next_rdata[CFG_CAP_LSB +: CAP_W] = cap_field;
                end
                OFF_SCRATCH: next_rdata = scratch;
                OFF_TRAP_MATCH: next_rdata = trap_match;
                OFF_ERR_MARK: next_rdata = err_mark;
                default: next_rdata = '0;
            endcase
        end
    end

    // ----------------------------------------
    // Registers under hard power-on reset
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state <= RSC_SCAN;
            osr <= OSR_RST;
            shadow <= OSR_RST;
            narrow <= 1'b0;
            cap_field <= '0;
            trap_match <= TRAP_MATCH_RST;
            err_mark <= ERR_MARK_RST;
            trap_lvl <= '0;
            recov <= 1'b1;
            wdog_seen <= 1'b0;
            soft_s1 <= 1'b1;
            soft_s2 <= 1'b1;
            soft_s3 <= 1'b1;
            core_run <= 1'b0;
            wd_reset <= 1'b0;
            halted <= 1'b0;
            fatal <= 1'b0;
            err_cls <= 4'h0;
            rdata <= '0;
            PA_O <= '0;
            SOFT_RESET_O <= 1'b0;
        end else begin
            state <= next_state;
            osr <= next_osr;
            shadow <= next_shadow;
            narrow <= next_narrow;
            cap_field <= next_cap_field;
            trap_match <= next_trap_match;
            err_mark <= next_err_mark;
            trap_lvl <= next_trap_lvl;
            recov <= next_recov;
            wdog_seen <= next_wdog_seen;
            soft_s1 <= SYS_SOFT_RESET_N_I;
            soft_s2 <= soft_s1;
            soft_s3 <= soft_s2;
            core_run <= next_core_run;
            wd_reset <= next_wd_reset;
            halted <= next_halted;
            fatal <= next_fatal;
            err_cls <= next_err_cls;
            rdata <= next_rdata;
            PA_O <= mask_pa(PA_I, narrow);
            SOFT_RESET_O <= soft_fall;
        end
    end

    // Scratch word holds whatever power-up gives it
    always_ff @(posedge CLK_I) begin
        if (REG_WR_I && REG_ADDR_I == OFF_SCRATCH) begin
            scratch <= REG_WDATA_I;
        end
    end

    assign REG_RDATA_O = rdata;
    assign CORE_RUN_O = core_run;
    assign RECOVERY_STATE_O = recov;
    assign TRAP_LEVEL_O = trap_lvl;
    assign WD_RESET_O = wd_reset;
    assign HALTED_O = halted;
    assign FATAL_O = fatal;
    assign ERR_CLASS_O = err_cls;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_first_wdog;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_RUN && WDOG_TIMEOUT_I && !wdog_seen && !recov && !RECOVERY_EXIT_I
         && !soft_fall) |=> !recov && !wd_reset;
    endproperty
    a_first_wdog: assert property (p_first_wdog) else $error("first timeout left execute");
    property p_later_wdog;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_RUN && WDOG_TIMEOUT_I && wdog_seen && !soft_fall) |=> recov && wd_reset;
    endproperty
    a_later_wdog: assert property (p_later_wdog) else $error("later timeout not recovery");
    property p_top_trap;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_RUN && TRAP_I && !WDOG_TIMEOUT_I && trap_lvl == TOP_TRAP_LEVEL
         && !soft_fall) |=> wd_reset && recov && trap_lvl == TOP_TRAP_LEVEL;
    endproperty
    a_top_trap: assert property (p_top_trap) else $error("top level trap not routed");
    property p_no_run_before_load;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_SCAN && !(SCAN_DONE_I && !SCAN_EN_I)) |=> !CORE_RUN_O;
    endproperty
    a_no_run_before_load: assert property (p_no_run_before_load) else $error("ran early");
    property p_cfg_copy;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_SCAN && SCAN_DONE_I && !SCAN_EN_I) |=> narrow == $past(osr[OSR_NARROW_BIT]);
    endproperty
    a_cfg_copy: assert property (p_cfg_copy) else $error("width choice not copied");
    property p_osr_stable;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state != RSC_SCAN && !JTAG_UPDATE_I) |=> osr == $past(osr);
    endproperty
    a_osr_stable: assert property (p_osr_stable) else $error("status register changed");
    property p_jtag;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state != RSC_SCAN && JTAG_UPDATE_I) |=> osr == $past(shadow);
    endproperty
    a_jtag: assert property (p_jtag) else $error("test port update lost");
    property p_narrow;
        @(posedge CLK_I) disable iff (!RST_N_I)
        narrow |=> PA_O[PA_W-1:PA_NARROW_W] == 2'b00;
    endproperty
    a_narrow: assert property (p_narrow) else $error("high address bits leaked");
    property p_halt;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_ERROR && osr[OSR_HALT_BIT] && !soft_fall) |=> halted && !wd_reset;
    endproperty
    a_halt: assert property (p_halt) else $error("halt option ignored");
    property p_err_exit;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_ERROR && !osr[OSR_HALT_BIT]) |=> wd_reset && recov && core_run;
    endproperty
    a_err_exit: assert property (p_err_exit) else $error("error exit missed reset");
    property p_onehot;
        @(posedge CLK_I) disable iff (!RST_N_I)
        (state == RSC_RUN && ERR_VALID_I) |=> $onehot(ERR_CLASS_O);
    endproperty
    a_onehot: assert property (p_onehot) else $error("error class not unique");
    property p_soft;
        @(posedge CLK_I) disable iff (!RST_N_I)
        $fell(soft_s2) |=> SOFT_RESET_O ##1 !SOFT_RESET_O;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
    c_reset_recov: cover property (@(posedge CLK_I) disable iff (!RST_N_I) wd_reset && recov);
    c_halted: cover property (@(posedge CLK_I) disable iff (!RST_N_I) halted);
    c_jtag: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
        state == RSC_RUN && JTAG_UPDATE_I);
endmodule : rsc_top

/* File: logic/rsc_pkg.sv */
// Package: constants for the reset-state and scan configuration block
package rsc_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PORT_ID = 8'h00;    // bus_port_identity, read only
    localparam logic [7:0] OFF_BUS_CFG = 8'h4a;    // bus_config_register, read only here
    localparam logic [7:0] OFF_SCRATCH = 8'h4f;    // Scratch word, never reset
    localparam logic [7:0] OFF_TRAP_MATCH = 8'h60; // instruction_trap_match
    localparam logic [7:0] OFF_ERR_MARK = 8'h6e;   // error_source_marker
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [63:0] TRAP_MATCH_RST = 64'h0;
    localparam logic [63:0] ERR_MARK_RST = 64'h0;
    // Port identity fields packed high to low: cap, rq, dq, rdq, one, ecc, sreq, cookie
    localparam logic [63:0] PORT_ID_VALUE = {36'h0, 8'hfc, 1'b1, 1'b0, 1'b0, 2'b01,
                                             6'h00, 4'h1, 5'h1b};
    // ----------------------------------------
    // Operating status scan register layout
    // ----------------------------------------
    localparam int OSR_W = 8;
    localparam int OSR_NARROW_BIT = 0;   // pa_width_select: 1 = 41-bit mode
    localparam int OSR_HALT_BIT = 1;     // Stay halted in error state
    localparam int OSR_CAP_LSB = 2;      // master_capability_field
    localparam int CAP_W = 4;
    localparam logic [OSR_W-1:0] OSR_RST = 8'h00;
    // Bus config read layout
    localparam int CFG_WIDTH_BIT = 0;    // pa_width_select copy
    localparam int CFG_CAP_LSB = 4;
    // ----------------------------------------
    // Addresses and traps
    // ----------------------------------------
    localparam int PA_W = 43;
    localparam int PA_NARROW_W = 41;
    localparam int LVL_W = 3;            // trap_level_count width
    localparam logic [LVL_W-1:0] TOP_TRAP_LEVEL = 3'h5;
    // Error classes
    localparam logic [1:0] ERR_FATAL = 2'h0;
    localparam logic [1:0] ERR_STATE = 2'h1;
    localparam logic [1:0] ERR_URGENT = 2'h2;
    localparam logic [1:0] ERR_RESTRAIN = 2'h3;
    // Sequencer states
    typedef enum logic [1:0] {RSC_SCAN, RSC_RUN, RSC_ERROR, RSC_HALT} rsc_state_t;
endpackage : rsc_pkg

/* File: test/rsc_scan_ctrl.sv */
// System controller model: power-on scan load and later test-port rewrite
`timescale 1ns/1ps
module rsc_scan_ctrl import rsc_pkg::*; (
    // Clock
    input wire logic clk_i,
    // Scan and test-port path
    output logic scan_en_o,
    output logic scan_in_o,
    output logic scan_done_o,
    output logic jtag_update_o
);
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        scan_en_o = 1'b0;
        scan_in_o = 1'b0;
        scan_done_o = 1'b0;
        jtag_update_o = 1'b0;
    end
    // Whole word, top bit first so the last bit lands in bit0
    task automatic shift(input logic [OSR_W-1:0] v);
        for (int i = OSR_W - 1; i >= 0; i--) begin
            @(negedge clk_i);
            scan_en_o = 1'b1;
            scan_in_o = v[i];
        end
        @(negedge clk_i);
        scan_en_o = 1'b0;
        scan_in_o = ~scan_in_o; // Idle data is inverted so stale bits never look valid
    endtask : shift
    // Power-on load: shifts, then done, all before the core runs
    task automatic load(input logic [OSR_W-1:0] v);
        shift(v);
        scan_done_o = 1'b1;
        @(negedge clk_i);
        scan_done_o = 1'b0;
    endtask : load
    // Rewrite after power-on through the test port
    task automatic update(input logic [OSR_W-1:0] v);
        shift(v);
        jtag_update_o = 1'b1;
        @(negedge clk_i);
        jtag_update_o = 1'b0;
    endtask : update
endmodule : rsc_scan_ctrl

/* File: test/rsc_testbench.sv */
// Self-checking bench for the reset-state and scan configuration block
`timescale 1ns/1ps
module testbench import rsc_pkg::*; ;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    localparam logic [4:0] E_WD = 5'h01; // Event bits: wdog, trap, ret, exit, err
    localparam logic [4:0] E_TR = 5'h02;
    localparam logic [4:0] E_RET = 5'h04;
    localparam logic [4:0] E_EXIT = 5'h08;
    localparam logic [4:0] E_ERR = 5'h10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_n = 1'b1;
    logic [4:0] ev = 5'h00;
    logic [1:0] ecls = 2'h0;
    logic [PA_W-1:0] pa = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [63:0] wdata = 64'h0;
    wire logic s_en, s_in, s_done, j_upd;
    logic [PA_W-1:0] pa_o;
    logic [63:0] rdata;
    logic run, rec, wd_rst, srst, halted, fatal;
    logic [LVL_W-1:0] lvl;
    logic [3:0] ecls_o;
    // Bench model state
    int seed = 50402;
    int n_errors = 0;
    int comparisons = 0;
    int m_lvl = 0;
    logic m_run, m_rec, m_wdrst, m_hlt, m_fat, m_nar;
    logic [3:0] m_cap;
    logic [7:0] offs [3] = '{OFF_SCRATCH, OFF_TRAP_MATCH, OFF_ERR_MARK};
    logic [63:0] vals [3];
    // 125 MHz clock
    always #4 clk = ~clk;
    // ----------------------------------------
    // Design and far-side model
    // ----------------------------------------
    rsc_top dut_u (.CLK_I(clk), .RST_N_I(rst_n), .SYS_SOFT_RESET_N_I(soft_n),
        .SCAN_EN_I(s_en), .SCAN_IN_I(s_in), .SCAN_DONE_I(s_done), .JTAG_UPDATE_I(j_upd),
        .WDOG_TIMEOUT_I(ev[0]), .TRAP_I(ev[1]), .TRAP_RET_I(ev[2]), .RECOVERY_EXIT_I(ev[3]),
        .ERR_VALID_I(ev[4]), .ERR_CLASS_I(ecls), .PA_I(pa), .PA_O(pa_o), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .CORE_RUN_O(run), .RECOVERY_STATE_O(rec), .TRAP_LEVEL_O(lvl), .WD_RESET_O(wd_rst),
        .SOFT_RESET_O(srst), .HALTED_O(halted), .FATAL_O(fatal), .ERR_CLASS_O(ecls_o));
    rsc_scan_ctrl ctrl_u (.clk_i(clk), .scan_en_o(s_en), .scan_in_o(s_in),
        .scan_done_o(s_done), .jtag_update_o(j_upd));
    // ----------------------------------------
    // Compare tasks and bus helpers
    // ----------------------------------------
    task automatic chk64(input string nm, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk64
    // Status flags; level only where the model knows it
    task automatic chk_st(input bit use_lvl);
        comparisons++;
        if ({run, rec, wd_rst, halted, fatal} !== {m_run, m_rec, m_wdrst, m_hlt, m_fat} ||
            (use_lvl && lvl !== 3'(m_lvl))) begin
            n_errors++;
            $display("CHECK FAILED status expected %b level %0d seen %b level %0d",
                {m_run, m_rec, m_wdrst, m_hlt, m_fat}, m_lvl,
                {run, rec, wd_rst, halted, fatal}, lvl);
        end
        m_wdrst = 1'b0; // Pulse lasts one cycle only
    endtask : chk_st
    // One-cycle event pulse; outputs answer by the next falling edge
    task automatic fire(input logic [4:0] b, input logic [1:0] c = 2'h0);
        @(negedge clk);
        ev = b;
        ecls = c;
        @(negedge clk);
        ev = 5'h00;
    endtask : fire
    task automatic reg_wr(input logic [7:0] a, input logic [63:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] a, input logic [63:0] e);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        @(negedge clk);
        rd = 1'b0;
        chk64("rdata", e, rdata);
    endtask : reg_chk
    function automatic logic [63:0] cfg_exp();
        cfg_exp = (64'(m_cap) << CFG_CAP_LSB) | (64'(m_nar) << CFG_WIDTH_BIT);
    endfunction : cfg_exp
    // Random addresses, masked by the mode fixed at power-on
    task automatic pa_run();
        logic [63:0] r;
        repeat (4) begin
            r = {$random(seed), $random(seed)};
            @(negedge clk);
            pa = r[PA_W-1:0];
            @(negedge clk);
            chk64("pa", m_nar ? 64'(pa[PA_NARROW_W-1:0]) : 64'(pa), 64'(pa_o));
        end
    endtask : pa_run
    // Hard reset, then scan load; core must wait for done
    task automatic hard_reset(input logic [7:0] osr);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        {m_run, m_rec, m_wdrst, m_hlt, m_fat} = 5'b01000;
        m_lvl = 0;
        chk_st(1);
        ctrl_u.load(osr);
        m_run = 1'b1;
        m_nar = osr[OSR_NARROW_BIT];
        m_cap = osr[OSR_CAP_LSB +: CAP_W];
        chk_st(1);
        reg_chk(OFF_BUS_CFG, cfg_exp());
    endtask : hard_reset
    // Falling soft reset input; pulse within a bounded wait
    task automatic soft_reset();
        int k;
        @(negedge clk);
        soft_n = 1'b0;
        for (k = 0; k < 12 && srst !== 1'b1; k++) @(negedge clk);
        chk64("soft", 64'h1, 64'(srst));
        {m_run, m_rec, m_wdrst, m_hlt, m_fat} = 5'b11000;
        m_lvl = 0;
        chk_st(1);
        soft_n = 1'b1;
    endtask : soft_reset
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] osr;
        osr = 8'h00;
        osr[OSR_CAP_LSB +: CAP_W] = 4'($random(seed));
        osr[OSR_NARROW_BIT] = 1'b1;
        hard_reset(osr);
        reg_chk(OFF_PORT_ID, PORT_ID_VALUE);
        reg_chk(OFF_TRAP_MATCH, TRAP_MATCH_RST);
        reg_chk(OFF_ERR_MARK, ERR_MARK_RST);
        reg_chk(8'h10, 64'h0);
        reg_wr(OFF_BUS_CFG, '1);
        reg_wr(OFF_PORT_ID, '1);
        reg_chk(OFF_BUS_CFG, cfg_exp());
        reg_chk(OFF_PORT_ID, PORT_ID_VALUE);
        foreach (offs[i]) begin
            vals[i] = {$random(seed), $random(seed)};
            reg_wr(offs[i], vals[i]);
            reg_chk(offs[i], vals[i]);
        end
        pa_run();
        $display("test registers and narrow mode done");
        // First timeout stays in execute, the second enters recovery
        fire(E_EXIT);
        m_rec = 1'b0;
        chk_st(1);
        fire(E_WD);
        m_lvl = 1;
        chk_st(1);
        fire(E_WD);
        {m_wdrst, m_rec} = 2'b11;
        chk_st(0);
        soft_reset();
        // Leave recovery so that the top-level trap has to enter it again
        fire(E_EXIT);
        m_rec = 1'b0;
        chk_st(1);
        // Climb to the top level, then one more trap
        repeat (5) begin
            fire(E_TR);
            m_lvl++;
            chk_st(1);
        end
        fire(E_TR);
        {m_wdrst, m_rec} = 2'b11;
        chk_st(1);
        fire(E_RET);
        m_lvl--;
        chk_st(1);
        $display("test traps done");
        for (int c = 2; c < 4; c++) begin
            fire(E_ERR, 2'(c));
            chk64("class", 64'h1 << c, 64'(ecls_o));
            chk_st(1);
        end
        fire(E_ERR, ERR_STATE);
        chk64("class", 64'h2, 64'(ecls_o));
        m_run = 1'b0;
        chk_st(1);
        @(negedge clk);
        {m_run, m_rec, m_wdrst} = 3'b111;
        chk_st(0);
        soft_reset();
        foreach (offs[i]) reg_chk(offs[i], vals[i]);
        // Test-port rewrite sets stay-halted; width mode keeps its power-on value
        osr[OSR_HALT_BIT] = 1'b1;
        ctrl_u.update(osr);
        reg_chk(OFF_BUS_CFG, cfg_exp());
        fire(E_ERR, ERR_STATE);
        m_run = 1'b0;
        chk_st(1);
        @(negedge clk);
        m_hlt = 1'b1;
        chk_st(1);
        soft_reset();
        fire(E_ERR, ERR_FATAL);
        chk64("class", 64'h1, 64'(ecls_o));
        @(negedge clk);
        chk64("fatal", 64'h2, 64'({fatal, run}));
        soft_reset();
        $display("test errors and soft reset done");
        osr[OSR_NARROW_BIT] = 1'b0;
        osr[OSR_CAP_LSB +: CAP_W] = ~osr[OSR_CAP_LSB +: CAP_W];
        hard_reset(osr);
        pa_run();
        $display("test wide mode done");
        give_verdict();
    end
    // Hang guard, far beyond the couple of hundred cycles needed
    initial begin
        #400000;
        n_errors++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule : testbench
